//--- hdl/spi_defs.svh
/*
  Register offsets, status bit positions and timing counts of the serial port.
  Assumes inclusion by bare name from the package and the port module.
*/
`ifndef SPI_DEFS_SVH
`define SPI_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define ADDR_DATA 2'h0
`define ADDR_CTRL 2'h1
`define ADDR_STAT 2'h2

// ****************************************
// Status and control register bits
// ****************************************
`define ST_RXF   7
`define ST_ERROR_IRQ_ENABLE 6
`define ST_OVR   5
`define ST_FLT   4
`define ST_TXE   3
`define ST_SFEN  2

// ****************************************
// Timing
// ****************************************
`define CLK_NS       4
`define SCK_HALF_NS  24
`define SCK_HALF_CYC (`SCK_HALF_NS / `CLK_NS)
`define LAST_EDGE    4'hF
`define BIT1_EDGE_P0 4'hC
`define BIT1_EDGE_P1 4'hD
`define PIN_IDLE     4'h1

`endif

//--- hdl/spi_pkg.sv
/*
  Types shared by the serial port modules.
  Assumes the constants header sits beside it.
*/
package spi_pkg;
  `include "spi_defs.svh"

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
  } pins_in_t;

  typedef struct packed {
    logic sck_out;
    logic sck_oe;
    logic mosi_out;
    logic mosi_oe;
    logic miso_out;
    logic miso_oe;
  } pins_out_t;

  typedef struct packed {
    logic rxie;
    logic master_select_bit;
    logic clock_polarity;
    logic clock_phase;
    logic pe;
    logic txie;
  } ctrl_t;

  typedef enum logic {IDLE, RUN} xfer_t;
endpackage

//--- hdl/pin_sync.sv
/*
  Two-stage synchroniser for the serial pins.
  Assumes pins are asynchronous to clk; reset is already synchronous-released.
*/
`timescale 1ns/10ps
`include "spi_defs.svh"
module pin_sync (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Pins
  input  wire spi_pkg::pins_in_t d,
  output spi_pkg::pins_in_t      q
);
  import spi_pkg::*;

  pins_in_t meta_q;

  // Only the second stage is visible outside
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= `PIN_IDLE;
      q      <= `PIN_IDLE;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

//--- hdl/spi_port.sv
/*
  Byte-wide serial port: transmit queue, receive buffer, overrun and
  select-fault detection, master clock generation and slave edge tracking.
  Assumes a register master on clk and pins asynchronous to clk.
*/
// Overview of operation
// - Master sends queued byte right after previous
// - Tx-empty high when buffer accepts a byte
// - Data write clears tx-empty, load sets it
// - Completed byte sets rx-full; status-then-data clears
// - No new byte: previous shift value resent
// - Idle end sets tx-empty within two cycles
// - Active slave reloads only after transfer ends
// - Unread buffer at bit-1 capture sets overrun
// - Overrun blocks new bytes, keeps old one
// - Overrun clears by status then data read
// - Overrun and fault share error request
// - Master select sets pin directions
// - Fault sets only while fault enable set
// - Master select low: fault, disable, empty, reset
// - Slave deselected mid-transfer raises fault
// - Slave transfer bounds depend on phase
// - Phase 0 select-deselect faults without clocks
// - Slave fault leaves port enabled
// - Deselected slave: output off, clocks ignored
// - Fault clears by status read, control write
// - Fault leaves master select untouched
// - Tx request needs tx enable and port enable
// - Rx request ignores port enable
`timescale 1ns/10ps
`include "spi_defs.svh"
module spi_port (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // Register port
  input  wire logic [1:0]        addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [7:0]        rdata,
  // Serial pins
  input  wire spi_pkg::pins_in_t pin_in,
  output spi_pkg::pins_out_t     pin_out,
  // Interrupt requests
  output logic                   irq_tx,
  output logic                   irq_rx_err
);
  import spi_pkg::*;

  // ****************************************
  // Reset release and pin sampling
  // ****************************************
  logic [1:0] rst_q;
  logic       rst_n;
  pins_in_t   pin_s;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  pin_sync u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (pin_in),
    .q     (pin_s)
  );

  // ****************************************
  // State
  // ****************************************
  ctrl_t      ctrl_q;
  xfer_t      state_q;
  logic       error_irq_enable_q;
  logic       sfen_q;
  logic [7:0] txbuf_q;
  logic [7:0] txlast_q;
  logic [7:0] shift_q;
  logic [7:0] rx_sh_q;
  logic [7:0] rx_buf_q;
  logic [7:0] rdata_q;
  logic [3:0] cnt_q;
  logic [3:0] div_q;
  logic       txfull_q;
  logic       rx_full_q;
  logic       ovr_q;
  logic       fault_q;
  logic       rx_arm_q;
  logic       ovr_arm_q;
  logic       f_arm_q;
  logic       f_seen_q;
  logic       sck_q;
  logic       sck_p_q;
  logic       ss_p_q;
  function automatic logic sel(input logic [1:0] a);
    return addr == a;
  endfunction

  // ****************************************
  // Decode and event terms
  // ****************************************
  logic       data_wr;
  logic       data_rd;
  logic       ctrl_wr;
  logic       stat_wr;
  logic       stat_rd;
  logic       tick;
  logic       sl_edge;
  logic       ev;
  logic       samp;
  logic       comp;
  logic       bit1_ev;
  logic       din;
  logic       mcond;
  logic       mflt;
  logic       scond;
  logic       fcond;
  logic       fault_ev;
  logic       fault_clr;
  logic       load;
  logic       start;
  logic       ss_fell;
  logic [7:0] rx_next;
  logic [7:0] load_data;

  assign data_wr = wr && sel(`ADDR_DATA);
  assign data_rd = rd && sel(`ADDR_DATA);
  assign ctrl_wr = wr && sel(`ADDR_CTRL);
  assign stat_wr = wr && sel(`ADDR_STAT);
  assign stat_rd = rd && sel(`ADDR_STAT);

  assign tick    = div_q == 4'(`SCK_HALF_CYC - 1);
  // Deselected slave sees no clock edges at all
  assign sl_edge = pin_s.sck != sck_p_q && !pin_s.ss_n;
  assign ev      = ctrl_q.pe && state_q == RUN && (ctrl_q.master_select_bit ? tick : sl_edge);
  assign samp    = !cnt_q[0] ^ ctrl_q.clock_phase;
  assign comp    = ev && cnt_q == `LAST_EDGE;
  assign bit1_ev = ev && samp && cnt_q == (ctrl_q.clock_phase ? `BIT1_EDGE_P1 : `BIT1_EDGE_P0);
  assign din     = ctrl_q.master_select_bit ? pin_s.miso : pin_s.mosi;
  assign rx_next = ctrl_q.clock_phase ? {rx_sh_q[6:0], din} : rx_sh_q;
  assign ss_fell = !pin_s.ss_n && ss_p_q;

  assign mcond    = ctrl_q.pe && ctrl_q.master_select_bit && !pin_s.ss_n;
  assign mflt     = sfen_q && mcond;
  assign scond    = ctrl_q.pe && !ctrl_q.master_select_bit && state_q == RUN && pin_s.ss_n;
  assign fcond    = sfen_q && (mcond || scond);
  // Only a rising select counts, so a held-high slave faults once
  assign fault_ev = mflt || (sfen_q && scond && !ss_p_q);
  assign fault_clr = ctrl_wr && f_arm_q && !f_seen_q && !fcond;

  // Active slave may only reload at the end of its transfer
  assign load      = txfull_q && ctrl_q.pe && !mflt && (state_q == IDLE || comp);
  assign load_data = load ? txbuf_q : txlast_q;

  always_comb begin
    start = 1'b0;
    if (ctrl_q.pe && state_q == IDLE && !mflt) begin
      if (ctrl_q.master_select_bit) begin
        start = load;
      end else if (!ctrl_q.clock_phase) begin
        start = ss_fell;
      end else begin
        start = pin_s.sck != sck_p_q && !pin_s.ss_n;
      end
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q  <= '0;
      error_irq_enable_q <= 1'b0;
      sfen_q  <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        ctrl_q <= ctrl_t'(wdata[5:0]);
      end
      // Master select bit is left alone by a fault
      if (mflt) begin
        ctrl_q.pe <= 1'b0;
      end
      if (stat_wr) begin
        error_irq_enable_q <= wdata[`ST_ERROR_IRQ_ENABLE];
        sfen_q  <= wdata[`ST_SFEN];
      end
    end
  end

  // ****************************************
  // Transmit queue
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txbuf_q  <= 8'h00;
      txlast_q <= 8'h00;
      txfull_q <= 1'b0;
    end else begin
      if (data_wr) begin
        txbuf_q <= wdata;
      end
      if (load) begin
        txlast_q <= txbuf_q;
      end
      if (!ctrl_q.pe || mflt) begin
        txfull_q <= 1'b0;
      end else if (data_wr) begin
        txfull_q <= 1'b1;
      end else if (load) begin
        txfull_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Transfer engine
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= IDLE;
      cnt_q   <= 4'h0;
      shift_q <= 8'h00;
    end else if (!ctrl_q.pe || mflt) begin
      state_q <= IDLE;
      cnt_q   <= 4'h0;
      shift_q <= 8'h00;
    end else if (state_q == IDLE) begin
      if (start) begin
        state_q <= RUN;
        shift_q <= load_data;
        cnt_q   <= (!ctrl_q.master_select_bit && ctrl_q.clock_phase) ? 4'h1 : 4'h0;
      end
    end else if (!ctrl_q.master_select_bit && !ctrl_q.clock_phase && ss_fell) begin
      cnt_q   <= 4'h0;
      shift_q <= txlast_q;
    end else if (ev) begin
      cnt_q <= cnt_q + 4'h1;
      if (comp) begin
        if (ctrl_q.master_select_bit && load) begin
          shift_q <= txbuf_q;
        end else begin
          state_q <= IDLE;
        end
      end else if (!samp && !(ctrl_q.clock_phase && cnt_q == 4'h0)) begin
        shift_q <= {shift_q[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_sh_q <= 8'h00;
    end else if (ev && samp) begin
      rx_sh_q <= {rx_sh_q[6:0], din};
    end
  end

  // Master clock runs only while a byte is on the wire
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 4'h0;
      sck_q <= 1'b0;
    end else if (state_q != RUN || !ctrl_q.master_select_bit || !ctrl_q.pe) begin
      div_q <= 4'h0;
      sck_q <= ctrl_q.clock_polarity;
    end else if (tick) begin
      div_q <= 4'h0;
      sck_q <= !sck_q;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_p_q <= 1'b0;
      ss_p_q  <= 1'b1;
    end else begin
      sck_p_q <= pin_s.sck;
      ss_p_q  <= pin_s.ss_n;
    end
  end

  // ****************************************
  // Receive buffer and overrun
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_buf_q  <= 8'h00;
      rx_full_q <= 1'b0;
      ovr_q     <= 1'b0;
      rx_arm_q  <= 1'b0;
      ovr_arm_q <= 1'b0;
    end else begin
      if (stat_rd) begin
        rx_arm_q  <= rx_full_q;
        ovr_arm_q <= ovr_q;
      end else if (data_rd) begin
        rx_arm_q  <= 1'b0;
        ovr_arm_q <= 1'b0;
      end
      // Set wins over a clear in the same cycle
      if (comp && !ovr_q) begin
        rx_buf_q  <= rx_next;
        rx_full_q <= 1'b1;
      end else if (data_rd && rx_arm_q) begin
        rx_full_q <= 1'b0;
      end
      if (bit1_ev && rx_full_q) begin
        ovr_q <= 1'b1;
      end else if (data_rd && ovr_arm_q) begin
        ovr_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Select fault
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_q  <= 1'b0;
      f_arm_q  <= 1'b0;
      f_seen_q <= 1'b0;
    end else begin
      if (fault_ev) begin
        fault_q <= 1'b1;
      end else if (fault_clr) begin
        fault_q <= 1'b0;
      end
      if (stat_rd) begin
        f_arm_q  <= fault_q;
        f_seen_q <= fcond;
      end else begin
        f_seen_q <= f_seen_q || fcond;
        if (ctrl_wr) begin
          f_arm_q <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  function automatic logic [7:0] read_mux(input logic [1:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `ADDR_DATA: v = rx_buf_q;
      `ADDR_CTRL: v = {2'h0, ctrl_q};
      `ADDR_STAT: begin
        v[`ST_RXF]   = rx_full_q;
        v[`ST_ERROR_IRQ_ENABLE] = error_irq_enable_q;
        v[`ST_OVR]   = ovr_q;
        v[`ST_FLT]   = fault_q;
        v[`ST_TXE]   = !txfull_q;
        v[`ST_SFEN]  = sfen_q;
      end
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd ? read_mux(addr) : 8'h00;
    end
  end
  assign rdata = rdata_q;

  // ****************************************
  // Pins and requests
  // ****************************************
  assign pin_out.sck_out  = sck_q;
  assign pin_out.sck_oe   = ctrl_q.pe && ctrl_q.master_select_bit;
  assign pin_out.mosi_out = shift_q[7];
  assign pin_out.mosi_oe  = ctrl_q.pe && ctrl_q.master_select_bit;
  assign pin_out.miso_out = shift_q[7];
  assign pin_out.miso_oe  = ctrl_q.pe && !ctrl_q.master_select_bit && !pin_s.ss_n;

  assign irq_tx     = !txfull_q && ctrl_q.txie && ctrl_q.pe;
  assign irq_rx_err = (rx_full_q && ctrl_q.rxie) || ((ovr_q || fault_q) && error_irq_enable_q);

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_write_fills_q: assert property (data_wr && ctrl_q.pe && !mflt |=> txfull_q)
    else $error("write did not queue byte");
  a_master_requeue: assert property (comp && ctrl_q.master_select_bit && load |=> state_q == RUN && cnt_q == 4'h0)
    else $error("master did not chain queued byte");
  a_idle_empty: assert property (txfull_q && ctrl_q.pe && state_q == IDLE && !data_wr && !mflt
    |-> ##[1:2] !txfull_q)
    else $error("tx empty late");
  a_slave_hold: assert property (state_q == RUN && !ctrl_q.master_select_bit && !comp |=> $stable(txlast_q))
    else $error("slave reloaded mid transfer");
  a_rx_full_set: assert property (comp && !ovr_q |=> rx_full_q && rx_buf_q == $past(rx_next))
    else $error("rx byte not buffered");
  a_ovr_set: assert property (bit1_ev && rx_full_q |=> ovr_q)
    else $error("overrun missed");
  a_ovr_block: assert property (ovr_q && comp |=> $stable(rx_buf_q))
    else $error("byte entered during overrun");
  a_master_fault: assert property (mflt |=> fault_q && !ctrl_q.pe && !txfull_q && state_q == IDLE)
    else $error("master fault actions missing");
  a_miso_off: assert property (pin_s.ss_n |-> !pin_out.miso_oe)
    else $error("deselected slave drives");
  a_tx_req: assert property (data_wr && ctrl_q.pe && !mflt |=> !irq_tx)
    else $error("tx request stayed up after a queued write");

  c_back_to_back: cover property (comp && ctrl_q.master_select_bit && load);
  c_overrun: cover property (bit1_ev && rx_full_q);
  c_slave_fault: cover property (scond && !ss_p_q && sfen_q);
  c_fault_clear: cover property (fault_clr);
endmodule

//--- verif/far_end.sv
/*
  Far-side serial device: slave while the port drives the clock, else master.
  Assumes the bench resolves each shared pin from the port's output enables.
*/
`timescale 1ns/10ps
module far_end (
  // Wire levels
  input  wire logic port_sck,
  input  wire logic port_mosi,
  input  wire logic port_miso,
  input  wire logic slave_role,
  // Far-side drive
  output logic      sck,
  output logic      mosi,
  output logic      miso,
  output logic      ss_n
);
  logic [7:0] reply;
  logic [7:0] sh;
  logic [7:0] acc;
  logic [7:0] rx_byte;
  logic [7:0] got_q[$];
  logic       alt;
  int         nbit;
  realtime    last_t;
  realtime    gap;

  // **********
  // Slave role, phase 0, idle-low clock
  // **********
  initial begin
    reply = 8'hC3;
    sh = 8'hC3;
    nbit = 0;
    sck = 1'b0;
    mosi = 1'b0;
    ss_n = 1'b1;
    alt = 1'b0;
    last_t = 0;
  end
  // Released line keeps changing so a stale level never passes
  always #24 alt = ~alt;
  assign miso = slave_role ? sh[7] : alt;

  always @(posedge port_sck) if (slave_role) begin
    if (nbit == 0) gap = $realtime - last_t;
    acc = {acc[6:0], port_mosi};
    nbit++;
    if (nbit == 8) got_q.push_back(acc);
  end

  // Reply grows each byte so a dropped byte shows
  always @(negedge port_sck) if (slave_role) begin
    last_t = $realtime;
    sh = {sh[6:0], 1'b0};
    if (nbit == 8) begin
      nbit = 0;
      reply = reply + 8'h11;
      sh = reply;
    end
  end

  // **********
  // Master role: 48 ns clock, still between frames
  // **********
  task automatic xfer(input logic [7:0] tx, input logic sel, input logic clock_phase);
    // Step off the port's clock edge so pins never race its flops
    #1;
    ss_n = ~sel;
    mosi = tx[7];
    #24;
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      sck = 1'b1;
      if (!clock_phase) rx_byte = {rx_byte[6:0], port_miso};
      #24;
      sck = 1'b0;
      if (clock_phase) rx_byte = {rx_byte[6:0], port_miso};
      else if (i > 0) mosi = tx[i-1];
      #24;
    end
    ss_n = 1'b1;
    mosi = ~mosi;
  endtask
endmodule

//--- verif/tb.sv
/*
  Self-checking bench: master, overrun, fault and slave runs.
  Assumes package, port and far-side model are compiled before it.
*/
`timescale 1ns/10ps
`include "spi_defs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; $display("mismatch %0t ns: %h not %h", $time, g, e); end end
module tb;
  import spi_pkg::*;
  logic       clk;
  logic       reset_n;
  logic [1:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  pins_in_t   pin_in;
  pins_out_t  pin_out;
  logic       irq_tx;
  logic       irq_rx_err;
  logic       f_sck;
  logic       f_mosi;
  logic       f_miso;
  logic       f_ss_n;
  logic [7:0] v;
  int         bad_count;
  int         checks;

  spi_port u_spi_port (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .irq_tx(irq_tx), .irq_rx_err(irq_rx_err));
  far_end u_far_end (.port_sck(pin_in.sck), .port_mosi(pin_in.mosi), .port_miso(pin_in.miso),
    .slave_role(pin_out.sck_oe), .sck(f_sck), .mosi(f_mosi), .miso(f_miso), .ss_n(f_ss_n));
  assign pin_in = {pin_out.sck_oe ? pin_out.sck_out : f_sck, pin_out.mosi_oe ? pin_out.mosi_out : f_mosi,
                   pin_out.miso_oe ? pin_out.miso_out : f_miso, f_ss_n};

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // **********
  // Register access and waits
  // **********
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [1:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic wait_stat(input int b, input logic val);
    for (int i = 0; i < 400; i++) begin
      rd_reg(`ADDR_STAT);
      if (v[b] === val) return;
    end
    bad_count++;
    end_of_test();
  endtask

  task automatic wait_got(input int n);
    for (int i = 0; i < 2000 && u_far_end.got_q.size() < n; i++) @(posedge clk);
    if (u_far_end.got_q.size() < n) begin
      bad_count++;
      end_of_test();
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // **********
  // Main sequence
  // **********
  initial begin
    reset_n = 1'b0;
    addr = 2'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    bad_count = 0;
    checks = 0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(`ADDR_STAT);
    `CHK(v, 8'h08)
    rd_reg(`ADDR_CTRL);
    `CHK(v, 8'h00)
    wr_reg(2'h3, 8'hFF);
    rd_reg(2'h3);
    `CHK(v, 8'h00)
    // Master: queued pair, overrun on the second byte
    wr_reg(`ADDR_STAT, 8'h40);
    wr_reg(`ADDR_CTRL, 8'h13);
    @(negedge clk);
    `CHK({pin_out.sck_oe, pin_out.mosi_oe, pin_out.miso_oe}, 3'b110)
    `CHK(irq_tx, 1'b1)
    wr_reg(`ADDR_DATA, 8'hA5);
    @(negedge clk);
    `CHK(irq_tx, 1'b0)
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK(irq_tx, 1'b1)
    wr_reg(`ADDR_DATA, 8'h3C);
    rd_reg(`ADDR_STAT);
    `CHK(v[`ST_TXE], 1'b0)
    wait_got(2);
    `CHK(u_far_end.got_q[0], 8'hA5)
    `CHK(u_far_end.got_q[1], 8'h3C)
    `CHK(u_far_end.gap < 36.0, 1'b1)
    // Second byte ends one half period after the last capture
    repeat (16) @(posedge clk);
    rd_reg(`ADDR_STAT);
    `CHK(v, 8'hE8)
    `CHK(irq_rx_err, 1'b1)
    rd_reg(`ADDR_DATA);
    `CHK(v, 8'hC3)
    rd_reg(`ADDR_STAT);
    `CHK(v, 8'h48)
    `CHK(irq_rx_err, 1'b0)
    wr_reg(`ADDR_DATA, 8'h7E);
    wait_stat(`ST_RXF, 1'b1);
    `CHK(u_far_end.got_q[2], 8'h7E)
    wr_reg(`ADDR_CTRL, 8'h30);
    @(negedge clk);
    `CHK({irq_tx, irq_rx_err}, 2'b01)
    rd_reg(`ADDR_DATA);
    `CHK(v, 8'hE5)
    rd_reg(`ADDR_STAT);
    `CHK(v[`ST_RXF], 1'b0)
    // Master select fault
    wr_reg(`ADDR_CTRL, 8'h13);
    u_far_end.ss_n <= 1'b0;
    repeat (8) @(posedge clk);
    rd_reg(`ADDR_STAT);
    `CHK(v[`ST_FLT], 1'b0)
    u_far_end.ss_n <= 1'b1;
    repeat (4) @(posedge clk);
    wr_reg(`ADDR_STAT, 8'h44);
    u_far_end.ss_n <= 1'b0;
    repeat (8) @(posedge clk);
    rd_reg(`ADDR_STAT);
    `CHK(v, 8'h5C)
    rd_reg(`ADDR_CTRL);
    `CHK(v, 8'h11)
    `CHK({irq_rx_err, pin_out.sck_oe}, 2'b10)
    // Disabled port: a low select is no fault condition any more
    wr_reg(`ADDR_CTRL, 8'h08);
    rd_reg(`ADDR_STAT);
    `CHK(v[`ST_FLT], 1'b0)
    `CHK(pin_out.sck_out, 1'b1)
    u_far_end.ss_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_reg(`ADDR_STAT);
    wr_reg(`ADDR_CTRL, 8'h02);
    rd_reg(`ADDR_STAT);
    `CHK(v[`ST_FLT], 1'b0)
    // Slave, phase 0
    `CHK(pin_out.miso_oe, 1'b0)
    wr_reg(`ADDR_DATA, 8'h5A);
    u_far_end.xfer(8'h96, 1'b1, 1'b0);
    `CHK(u_far_end.rx_byte, 8'h5A)
    wait_stat(`ST_RXF, 1'b1);
    rd_reg(`ADDR_DATA);
    `CHK(v, 8'h96)
    u_far_end.xfer(8'h21, 1'b1, 1'b0);
    `CHK(u_far_end.rx_byte, 8'h5A)
    wait_stat(`ST_RXF, 1'b1);
    `CHK(v[`ST_FLT], 1'b0)
    rd_reg(`ADDR_DATA);
    `CHK(v, 8'h21)
    u_far_end.ss_n <= 1'b0;
    repeat (10) @(posedge clk);
    u_far_end.ss_n <= 1'b1;
    repeat (10) @(posedge clk);
    rd_reg(`ADDR_STAT);
    `CHK(v[`ST_FLT], 1'b1)
    `CHK(irq_rx_err, 1'b1)
    rd_reg(`ADDR_CTRL);
    `CHK(v, 8'h02)
    // Running slave still deselected: this clear is refused
    wr_reg(`ADDR_CTRL, 8'h00);
    rd_reg(`ADDR_STAT);
    `CHK(v[`ST_FLT], 1'b1)
    wr_reg(`ADDR_CTRL, 8'h06);
    rd_reg(`ADDR_STAT);
    `CHK(v[`ST_FLT], 1'b0)
    // Slave, phase 1
    u_far_end.ss_n <= 1'b0;
    repeat (10) @(posedge clk);
    u_far_end.ss_n <= 1'b1;
    u_far_end.xfer(8'hFF, 1'b0, 1'b1);
    repeat (4) @(posedge clk);
    rd_reg(`ADDR_STAT);
    `CHK(v & 8'h90, 8'h00)
    wr_reg(`ADDR_DATA, 8'h3B);
    fork
      u_far_end.xfer(8'h4D, 1'b1, 1'b1);
      begin
        repeat (30) @(posedge clk);
        `CHK(pin_out.miso_oe, 1'b1)
        wr_reg(`ADDR_DATA, 8'hE7);
        rd_reg(`ADDR_STAT);
        `CHK(v[`ST_TXE], 1'b0)
      end
    join
    `CHK(u_far_end.rx_byte, 8'h3B)
    wait_stat(`ST_RXF, 1'b1);
    rd_reg(`ADDR_DATA);
    `CHK(v, 8'h4D)
    u_far_end.xfer(8'h00, 1'b1, 1'b1);
    `CHK(u_far_end.rx_byte, 8'hE7)
    end_of_test();
  end
endmodule
